// ==== core/p2dec_pkg.sv ====
// package of constants and types shared by the page-two opcode decoder files
package p2dec_pkg;

  // prefix byte that selects the second opcode page
  localparam logic [7:0]  PREBYTE_PAGE2 = 8'h9e;

  // step applied to the index pair by post-increment forms
  localparam logic [15:0] HX_STEP       = 16'h0001;

  // reset values of registered outputs
  localparam logic [15:0] RST_ADDR      = 16'h0000;
  localparam logic [7:0]  RST_BYTE      = 8'h00;

  // operand byte counts per addressing form
  localparam logic [1:0]  LEN_NONE      = 2'h0;
  localparam logic [1:0]  LEN_ONE       = 2'h1;
  localparam logic [1:0]  LEN_TWO       = 2'h2;

  // upper nibbles of decoded opcode groups
  localparam logic [3:0]  NIB_RMW_SP    = 4'h6;
  localparam logic [3:0]  NIB_LONG_OFS  = 4'hd;
  localparam logic [3:0]  NIB_SHORT_OFS = 4'he;
  localparam logic [3:0]  NIB_NO_OFS    = 4'hf;

  // individual opcodes handled outside the nibble groups
  localparam logic [7:0]  OPC_CBEQ_IX1P = 8'h61;
  localparam logic [7:0]  OPC_CBEQ_IXP  = 8'h71;
  localparam logic [7:0]  OPC_MOV_DD    = 8'h4e;
  localparam logic [7:0]  OPC_MOV_DIXP  = 8'h5e;
  localparam logic [7:0]  OPC_MOV_IMD   = 8'h6e;
  localparam logic [7:0]  OPC_MOV_IXPD  = 8'h7e;
  localparam logic [7:0]  OPC_P2_LDHX2  = 8'hbe;
  localparam logic [7:0]  OPC_P2_LDHX1  = 8'hce;
  localparam logic [7:0]  OPC_P2_CPHX   = 8'hf3;
  localparam logic [7:0]  OPC_P2_LDHXSP = 8'hfe;
  localparam logic [7:0]  OPC_P2_STHXSP = 8'hff;

  // addressing forms resolved by the decoder
  typedef enum logic [3:0] {
    MD_OTHER,
    MD_STACK_REL_SHORT_OFFSET,
    MD_STACK_REL_LONG_OFFSET,
    MD_INDEX_NO_OFFSET,
    MD_INDEX_SHORT_OFFSET,
    MD_INDEX_LONG_OFFSET,
    MD_INDEX_POSTINC,
    MD_INDEX_SHORT_OFFSET_POSTINC,
    MD_MOVE_DIRECT_TO_DIRECT,
    MD_MOVE_POSTINC_TO_DIRECT,
    MD_MOVE_IMMEDIATE_TO_DIRECT,
    MD_MOVE_DIRECT_TO_POSTINC,
    MD_ILLEGAL
  } p2dec_mode_t;

  // decoder sequencing states
  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_PAGE2_OPCODE,
    ST_OPERAND
  } p2dec_state_t;

endpackage

// ==== core/p2dec_ea_if.sv ====
// interface between the decoder sequencer and its address adder
`timescale 1ns/1ps
interface p2dec_ea_if;
  import p2dec_pkg::*;

  p2dec_mode_t mode;     // addressing form being resolved
  logic [15:0] offset;   // unsigned offset taken from the instruction
  logic [15:0] sp;       // stack pointer
  logic [15:0] hx;       // index register pair
  logic [15:0] ea;       // resolved operand address
  logic [15:0] hx_next;  // index pair after post-increment
  logic        postinc;  // form increments the index pair

  modport seq  (output mode, output offset, output sp, output hx,
                input ea, input hx_next, input postinc);
  modport calc (input mode, input offset, input sp, input hx,
                output ea, output hx_next, output postinc);
endinterface

// ==== core/p2dec_ea_calc.sv ====
// address adder resolving stack-relative and index-relative operand addresses
`timescale 1ns/1ps
module p2dec_ea_calc (
  p2dec_ea_if.calc ea_bus
);
  import p2dec_pkg::*;

  logic stack_base;  // form is relative to the stack pointer

  // select base and add the unsigned offset; wraps at 64k like the core's adder
  always_comb begin
    stack_base = (ea_bus.mode == MD_STACK_REL_SHORT_OFFSET) ||
                 (ea_bus.mode == MD_STACK_REL_LONG_OFFSET);
    if (stack_base) begin
      ea_bus.ea = ea_bus.sp + ea_bus.offset;
    end else begin
      ea_bus.ea = ea_bus.hx + ea_bus.offset;
    end
    // post-increment forms address first, then bump the pair by one
    ea_bus.postinc = (ea_bus.mode == MD_INDEX_POSTINC) ||
                     (ea_bus.mode == MD_INDEX_SHORT_OFFSET_POSTINC) ||
                     (ea_bus.mode == MD_MOVE_POSTINC_TO_DIRECT) ||
                     (ea_bus.mode == MD_MOVE_DIRECT_TO_POSTINC);
    ea_bus.hx_next = ea_bus.hx + HX_STEP;
  end

endmodule // p2dec_ea_calc

// ==== core/p2dec_top.sv ====
// page-two opcode decoder: prefix tracking, addressing form decode, operand addresses
`timescale 1ns/1ps

module p2dec_top (
  // clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST_B,
  // fetched byte stream
  input  wire logic              I_BYTE_VLD,
  input  wire logic              I_OPC_FIRST,
  input  wire logic [7:0]        I_BYTE,
  // core register values
  input  wire logic [15:0]       I_SP,
  input  wire logic [15:0]       I_HX,
  // decode result
  output logic                   O_DEC_VLD,
  output logic                   O_PAGE2,
  output logic [7:0]             O_OPCODE,
  output p2dec_pkg::p2dec_mode_t O_MODE,
  output logic                   O_ILLEGAL,
  output logic [15:0]            O_EA,
  output logic [15:0]            O_DST_EA,
  output logic [7:0]             O_IMM,
  // index pair update
  output logic                   O_HX_WR,
  output logic [15:0]            O_HX_NEXT
);
  import p2dec_pkg::*;

  // primary-page forms this decoder resolves; all else passes as other
  function automatic p2dec_mode_t page1_mode(input logic [7:0] opc);
    p2dec_mode_t m;
    m = MD_OTHER;
    if (opc == OPC_CBEQ_IX1P) begin
      m = MD_INDEX_SHORT_OFFSET_POSTINC;
    end else if (opc == OPC_CBEQ_IXP) begin
      m = MD_INDEX_POSTINC;
    end else if (opc == OPC_MOV_DD) begin
      m = MD_MOVE_DIRECT_TO_DIRECT;
    end else if (opc == OPC_MOV_DIXP) begin
      m = MD_MOVE_DIRECT_TO_POSTINC;
    end else if (opc == OPC_MOV_IMD) begin
      m = MD_MOVE_IMMEDIATE_TO_DIRECT;
    end else if (opc == OPC_MOV_IXPD) begin
      m = MD_MOVE_POSTINC_TO_DIRECT;
    end else if (opc[7:4] == NIB_LONG_OFS) begin
      m = MD_INDEX_LONG_OFFSET;
    end else if (opc[7:4] == NIB_SHORT_OFS) begin
      m = MD_INDEX_SHORT_OFFSET;
    end else if (opc[7:4] == NIB_NO_OFS) begin
      m = MD_INDEX_NO_OFFSET;
    end
    return m;
  endfunction

  // second-page map; holes in the map decode as illegal
  function automatic p2dec_mode_t page2_mode(input logic [7:0] opc);
    p2dec_mode_t m;
    m = MD_ILLEGAL;
    if (opc[7:4] == NIB_RMW_SP) begin
      // 62, 65 and 6e are not populated on this page
      if (opc[3:0] != 4'h2 && opc[3:0] != 4'h5 && opc[3:0] != 4'he) begin
        m = MD_STACK_REL_SHORT_OFFSET;
      end
    end else if (opc[7:4] == NIB_LONG_OFS) begin
      if (opc[3:0] != 4'hc && opc[3:0] != 4'hd) begin
        m = MD_STACK_REL_LONG_OFFSET;
      end
    end else if (opc[7:4] == NIB_SHORT_OFS) begin
      if (opc[3:0] != 4'hc && opc[3:0] != 4'hd) begin
        m = MD_STACK_REL_SHORT_OFFSET;
      end
    end else if (opc == OPC_P2_LDHX2) begin
      m = MD_INDEX_LONG_OFFSET;
    end else if (opc == OPC_P2_LDHX1) begin
      m = MD_INDEX_SHORT_OFFSET;
    end else if (opc == OPC_P2_CPHX || opc == OPC_P2_LDHXSP || opc == OPC_P2_STHXSP) begin
      m = MD_STACK_REL_SHORT_OFFSET;
    end
    return m;
  endfunction

  // operand bytes needed to resolve addresses (trailing branch offsets are not ours)
  function automatic logic [1:0] operand_len(input p2dec_mode_t m);
    logic [1:0] n;
    n = LEN_NONE;
    case (m)
      MD_STACK_REL_SHORT_OFFSET,
      MD_INDEX_SHORT_OFFSET,
      MD_INDEX_SHORT_OFFSET_POSTINC,
      MD_MOVE_POSTINC_TO_DIRECT,
      MD_MOVE_DIRECT_TO_POSTINC:    n = LEN_ONE;
      MD_STACK_REL_LONG_OFFSET,
      MD_INDEX_LONG_OFFSET,
      MD_MOVE_DIRECT_TO_DIRECT,
      MD_MOVE_IMMEDIATE_TO_DIRECT:  n = LEN_TWO;
      default:                      n = LEN_NONE;
    endcase
    return n;
  endfunction

  // sequencer state
  p2dec_state_t state_ff;      // where in the instruction we are
  p2dec_state_t nxt_state;
  p2dec_mode_t  mode_ff;       // form of the instruction in flight
  p2dec_mode_t  nxt_mode;
  logic         page2_ff;      // instruction came through the prefix
  logic         nxt_page2;
  logic [7:0]   opcode_ff;     // opcode byte in flight
  logic [7:0]   nxt_opcode;
  logic [7:0]   first_ff;      // first operand byte held for two-byte forms
  logic [7:0]   nxt_first;
  logic         got_one_ff;    // first operand byte already held
  logic         nxt_got_one;

  // completion request and its operands
  logic         finish;        // all address bytes present this cycle
  p2dec_mode_t  fin_mode;      // form being completed
  logic         fin_page2;
  logic [7:0]   fin_opcode;
  logic [7:0]   fin_b0;        // first operand byte
  logic [7:0]   fin_b1;        // second operand byte

  // registered outputs
  logic         dec_vld_ff;
  logic         nxt_dec_vld;
  logic         page2_out_ff;
  logic         nxt_page2_out;
  logic [7:0]   opcode_out_ff;
  logic [7:0]   nxt_opcode_out;
  p2dec_mode_t  mode_out_ff;
  p2dec_mode_t  nxt_mode_out;
  logic [15:0]  ea_ff;
  logic [15:0]  nxt_ea;
  logic [15:0]  dst_ea_ff;
  logic [15:0]  nxt_dst_ea;
  logic [7:0]   imm_ff;
  logic [7:0]   nxt_imm;
  logic         hx_wr_ff;
  logic         nxt_hx_wr;
  logic [15:0]  hx_next_ff;
  logic [15:0]  nxt_hx_next;

  logic         restart;       // an opcode byte starts a new instruction
  p2dec_mode_t  p1_mode;       // primary-page form of the incoming byte
  p2dec_mode_t  p2_mode;       // second-page form of the incoming byte

  p2dec_ea_if ea_bus ();

  p2dec_ea_calc u_ea_calc (
    .ea_bus (ea_bus.calc)
  );

  // sequencer: a byte flagged as first always restarts decode, so a
  // mispredicted fetch cannot leave the decoder stuck mid-instruction
  always_comb begin
    nxt_state   = state_ff;
    nxt_mode    = mode_ff;
    nxt_page2   = page2_ff;
    nxt_opcode  = opcode_ff;
    nxt_first   = first_ff;
    nxt_got_one = got_one_ff;
    finish      = 1'b0;
    fin_mode    = mode_ff;
    fin_page2   = page2_ff;
    fin_opcode  = opcode_ff;
    fin_b0      = first_ff;
    fin_b1      = I_BYTE;
    restart     = I_BYTE_VLD && I_OPC_FIRST;
    p1_mode     = page1_mode(I_BYTE);
    p2_mode     = page2_mode(I_BYTE);
    if (restart) begin
      nxt_got_one = 1'b0;
      nxt_opcode  = I_BYTE;
      if (I_BYTE == PREBYTE_PAGE2) begin
        nxt_state = ST_PAGE2_OPCODE;
        nxt_page2 = 1'b1;
      end else begin
        nxt_page2  = 1'b0;
        nxt_mode   = p1_mode;
        fin_mode   = p1_mode;
        fin_page2  = 1'b0;
        fin_opcode = I_BYTE;
        if (operand_len(p1_mode) == LEN_NONE) begin
          finish    = 1'b1;
          nxt_state = ST_OPCODE;
        end else begin
          nxt_state = ST_OPERAND;
        end
      end
    end else if (I_BYTE_VLD) begin
      case (state_ff)
        ST_PAGE2_OPCODE: begin
          // byte after the prefix is decoded against the second page
          nxt_opcode = I_BYTE;
          nxt_mode   = p2_mode;
          fin_mode   = p2_mode;
          fin_page2  = 1'b1;
          fin_opcode = I_BYTE;
          if (operand_len(p2_mode) == LEN_NONE) begin
            finish    = 1'b1;
            nxt_state = ST_OPCODE;
          end else begin
            nxt_state = ST_OPERAND;
          end
        end
        ST_OPERAND: begin
          if (operand_len(mode_ff) == LEN_TWO && !got_one_ff) begin
            nxt_first   = I_BYTE;
            nxt_got_one = 1'b1;
          end else begin
            // one-byte forms take this byte as the first operand
            if (operand_len(mode_ff) == LEN_ONE) begin
              fin_b0 = I_BYTE;
            end
            finish      = 1'b1;
            nxt_got_one = 1'b0;
            nxt_state   = ST_OPCODE;
          end
        end
        default: begin
          // stray operand bytes between instructions are ignored
          nxt_state = ST_OPCODE;
        end
      endcase
    end
  end

  // offset assembly for the adder: long offsets arrive high byte first
  always_comb begin
    ea_bus.mode = fin_mode;
    ea_bus.sp   = I_SP;
    ea_bus.hx   = I_HX;
    case (fin_mode)
      MD_STACK_REL_SHORT_OFFSET,
      MD_INDEX_SHORT_OFFSET,
      MD_INDEX_SHORT_OFFSET_POSTINC: ea_bus.offset = {8'h00, fin_b0};
      MD_STACK_REL_LONG_OFFSET,
      MD_INDEX_LONG_OFFSET:          ea_bus.offset = {fin_b0, fin_b1};
      default:                       ea_bus.offset = 16'h0000;
    endcase
  end

  // result assembly; moves place source in ea (immediate move: value in imm, ea zero) and destination in dst_ea
  always_comb begin
    nxt_dec_vld    = finish;
    nxt_page2_out  = page2_out_ff;
    nxt_opcode_out = opcode_out_ff;
    nxt_mode_out   = mode_out_ff;
    nxt_ea         = ea_ff;
    nxt_dst_ea     = dst_ea_ff;
    nxt_imm        = imm_ff;
    nxt_hx_wr      = 1'b0;
    nxt_hx_next    = hx_next_ff;
    if (finish) begin
      nxt_page2_out  = fin_page2;
      nxt_opcode_out = fin_opcode;
      nxt_mode_out   = fin_mode;
      nxt_ea         = ea_bus.ea;
      nxt_dst_ea     = RST_ADDR;
      nxt_imm        = RST_BYTE;
      nxt_hx_wr      = ea_bus.postinc;
      nxt_hx_next    = ea_bus.hx_next;
      case (fin_mode)
        MD_MOVE_DIRECT_TO_DIRECT: begin
          nxt_ea     = {8'h00, fin_b0};
          nxt_dst_ea = {8'h00, fin_b1};
        end
        MD_MOVE_POSTINC_TO_DIRECT: begin
          nxt_dst_ea = {8'h00, fin_b0};
        end
        MD_MOVE_IMMEDIATE_TO_DIRECT: begin
          nxt_imm    = fin_b0;
          nxt_ea     = RST_ADDR;
          nxt_dst_ea = {8'h00, fin_b1};
        end
        MD_MOVE_DIRECT_TO_POSTINC: begin
          nxt_ea     = {8'h00, fin_b0};
          nxt_dst_ea = ea_bus.ea;
        end
        MD_OTHER, MD_ILLEGAL: begin
          nxt_ea = RST_ADDR;
        end
        default: begin
          nxt_ea = ea_bus.ea;
        end
      endcase
    end
  end

  // state and output registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_ff      <= ST_OPCODE;
      mode_ff       <= MD_OTHER;
      page2_ff      <= 1'b0;
      opcode_ff     <= RST_BYTE;
      first_ff      <= RST_BYTE;
      got_one_ff    <= 1'b0;
      dec_vld_ff    <= 1'b0;
      page2_out_ff  <= 1'b0;
      opcode_out_ff <= RST_BYTE;
      mode_out_ff   <= MD_OTHER;
      ea_ff         <= RST_ADDR;
      dst_ea_ff     <= RST_ADDR;
      imm_ff        <= RST_BYTE;
      hx_wr_ff      <= 1'b0;
      hx_next_ff    <= RST_ADDR;
    end else begin
      state_ff      <= nxt_state;
      mode_ff       <= nxt_mode;
      page2_ff      <= nxt_page2;
      opcode_ff     <= nxt_opcode;
      first_ff      <= nxt_first;
      got_one_ff    <= nxt_got_one;
      dec_vld_ff    <= nxt_dec_vld;
      page2_out_ff  <= nxt_page2_out;
      opcode_out_ff <= nxt_opcode_out;
      mode_out_ff   <= nxt_mode_out;
      ea_ff         <= nxt_ea;
      dst_ea_ff     <= nxt_dst_ea;
      imm_ff        <= nxt_imm;
      hx_wr_ff      <= nxt_hx_wr;
      hx_next_ff    <= nxt_hx_next;
    end
  end

  // outputs straight from flip-flops, except O_ILLEGAL, which gates the registered mode with dec_vld_ff
  assign O_DEC_VLD = dec_vld_ff;
  assign O_PAGE2   = page2_out_ff;
  assign O_OPCODE  = opcode_out_ff;
  assign O_MODE    = mode_out_ff;
  assign O_ILLEGAL = dec_vld_ff && (mode_out_ff == MD_ILLEGAL);
  assign O_EA      = ea_ff;
  assign O_DST_EA  = dst_ea_ff;
  assign O_IMM     = imm_ff;
  assign O_HX_WR   = hx_wr_ff;
  assign O_HX_NEXT = hx_next_ff;

endmodule // p2dec_top

// ==== test/p2dec_prog_mem.sv ====
// program memory model streaming instruction bytes into the decoder
`timescale 1ns/1ps
module p2dec_prog_mem (
  // clock
  input  wire logic       i_clk,
  // fetched byte stream
  output logic            o_vld,
  output logic            o_first,
  output logic [7:0]      o_byte
);
  // idle until the first instruction is sent
  initial begin
    o_vld = 1'b0;
    o_first = 1'b0;
    o_byte = 8'h00;
  end

  // one instruction; gap stalls the fetch between bytes like slow memory
  // released lines show the inverted last byte so a stale value never looks valid
  task automatic send(input logic [7:0] b[$], input int gap);
    foreach (b[i]) begin
      o_vld = 1'b1;
      o_first = (i == 0);
      o_byte = b[i];
      @(posedge i_clk);
      #1;
      if (gap > 0 || i == b.size() - 1) begin
        o_vld = 1'b0;
        o_first = 1'b0;
        o_byte = ~b[i];
      end
      // no stall after the last byte, so the caller still sees the decode pulse
      if (gap > 0 && i < b.size() - 1) begin
        repeat (gap) @(posedge i_clk);
        #1;
      end
    end
  endtask
endmodule // p2dec_prog_mem

// ==== test/p2dec_asserts.sv ====
// concurrent checks on the page-two decoder top ports
`timescale 1ns/1ps
module p2dec_asserts
  import p2dec_pkg::*;
(
  // clock and reset
  input wire logic        I_CLK,
  input wire logic        I_RST_B,
  // byte stream and core registers
  input wire logic        I_BYTE_VLD,
  input wire logic        I_OPC_FIRST,
  input wire logic [7:0]  I_BYTE,
  input wire logic [15:0] I_SP,
  input wire logic [15:0] I_HX,
  // decode result
  input wire logic        O_DEC_VLD,
  input wire logic        O_PAGE2,
  input wire logic [7:0]  O_OPCODE,
  input wire p2dec_mode_t O_MODE,
  input wire logic        O_ILLEGAL,
  input wire logic [15:0] O_EA,
  input wire logic [15:0] O_DST_EA,
  input wire logic [7:0]  O_IMM,
  input wire logic        O_HX_WR,
  input wire logic [15:0] O_HX_NEXT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  // first byte of an instruction, and a following byte of the same one
  sequence s_first;
    I_BYTE_VLD && I_OPC_FIRST;
  endsequence
  sequence s_nxt;
    I_BYTE_VLD && !I_OPC_FIRST;
  endsequence
  // prefix then a page-two opcode of the given nibble, low nibbles c to f excluded
  sequence s_p2op(logic [3:0] nib);
    s_first ##0 I_BYTE == PREBYTE_PAGE2 ##1 s_nxt ##0 (I_BYTE[7:4] == nib && I_BYTE[3:0] < 4'hc);
  endsequence

  stack_short_a: assert property (s_p2op(NIB_SHORT_OFS) ##1 s_nxt |=> O_DEC_VLD && O_PAGE2 &&
    O_MODE == MD_STACK_REL_SHORT_OFFSET && O_EA == $past(I_SP) + {8'h00, $past(I_BYTE)})
    else $error("stack short offset address wrong");
  stack_long_a: assert property (s_p2op(NIB_LONG_OFS) ##1 s_nxt ##1 s_nxt |=> O_DEC_VLD &&
    O_MODE == MD_STACK_REL_LONG_OFFSET && O_EA == $past(I_SP) + {$past(I_BYTE, 2), $past(I_BYTE)})
    else $error("stack long offset address wrong");
  index_plain_a: assert property (s_first ##0 I_BYTE[7:4] == NIB_NO_OFS |=> O_DEC_VLD && !O_PAGE2 &&
    O_MODE == MD_INDEX_NO_OFFSET && O_EA == $past(I_HX))
    else $error("index no offset address wrong");
  index_short_a: assert property (s_first ##0 I_BYTE[7:4] == NIB_SHORT_OFS ##1 s_nxt |=> O_DEC_VLD &&
    O_MODE == MD_INDEX_SHORT_OFFSET && O_EA == $past(I_HX) + {8'h00, $past(I_BYTE)})
    else $error("index short offset address wrong");
  hx_step_a: assert property (O_HX_WR |-> O_DEC_VLD && O_HX_NEXT == $past(I_HX) + HX_STEP)
    else $error("index pair step wrong");
  postinc_mark_a: assert property (O_DEC_VLD && O_MODE inside {MD_INDEX_POSTINC,
    MD_INDEX_SHORT_OFFSET_POSTINC} |-> O_HX_WR)
    else $error("post increment write missing");
  move_dd_a: assert property (s_first ##0 I_BYTE == OPC_MOV_DD ##1 s_nxt ##1 s_nxt |=>
    O_MODE == MD_MOVE_DIRECT_TO_DIRECT && O_EA == {8'h00, $past(I_BYTE, 2)} && O_DST_EA == {8'h00, $past(I_BYTE)})
    else $error("direct move addresses wrong");
  move_imd_a: assert property (s_first ##0 I_BYTE == OPC_MOV_IMD ##1 s_nxt ##1 s_nxt |=>
    O_MODE == MD_MOVE_IMMEDIATE_TO_DIRECT && O_IMM == $past(I_BYTE, 2) && O_DST_EA == {8'h00, $past(I_BYTE)})
    else $error("immediate move fields wrong");
  illegal_flag_a: assert property (O_ILLEGAL |-> O_DEC_VLD && O_MODE == MD_ILLEGAL)
    else $error("illegal flag without illegal form");
endmodule // p2dec_asserts

bind p2dec_top p2dec_asserts u_chk (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_BYTE_VLD(I_BYTE_VLD),
  .I_OPC_FIRST(I_OPC_FIRST), .I_BYTE(I_BYTE), .I_SP(I_SP), .I_HX(I_HX), .O_DEC_VLD(O_DEC_VLD),
  .O_PAGE2(O_PAGE2), .O_OPCODE(O_OPCODE), .O_MODE(O_MODE), .O_ILLEGAL(O_ILLEGAL), .O_EA(O_EA),
  .O_DST_EA(O_DST_EA), .O_IMM(O_IMM), .O_HX_WR(O_HX_WR), .O_HX_NEXT(O_HX_NEXT));

// ==== test/p2dec_test.sv ====
// self-checking bench for the page-two opcode decoder
`timescale 1ns/1ps
module p2dec_test;
  import p2dec_pkg::*;
  logic        clk = 1'b0;     // 25 MHz core clock
  logic        rst_b = 1'b0;   // reset, active low
  logic [15:0] sp = 16'h0000;  // stack pointer fed to the decoder
  logic [15:0] hx = 16'h0000;  // index pair fed to the decoder
  logic        byte_vld;       // stream from the memory model
  logic        opc_first;
  logic [7:0]  fbyte;
  logic        dec_vld, page2, illegal, hx_wr;
  logic [7:0]  opcode, imm;
  p2dec_mode_t mode;
  logic [15:0] ea, dst_ea, hx_next;
  int          errors = 0;
  int          n_compared = 0;

  p2dec_prog_mem mem (.i_clk(clk), .o_vld(byte_vld), .o_first(opc_first), .o_byte(fbyte));
  p2dec_top dut (.I_CLK(clk), .I_RST_B(rst_b), .I_BYTE_VLD(byte_vld), .I_OPC_FIRST(opc_first),
    .I_BYTE(fbyte), .I_SP(sp), .I_HX(hx), .O_DEC_VLD(dec_vld), .O_PAGE2(page2), .O_OPCODE(opcode),
    .O_MODE(mode), .O_ILLEGAL(illegal), .O_EA(ea), .O_DST_EA(dst_ea), .O_IMM(imm),
    .O_HX_WR(hx_wr), .O_HX_NEXT(hx_next));

  // clock: half period 20 ns
  always #20 clk = ~clk;

  // compare one value and count it
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // wait a bounded time for the decode pulse, judge it, then let one edge pass
  task automatic get_dec(input logic p2, input logic [7:0] opc, input p2dec_mode_t md,
                         input logic [15:0] exp_ea, input logic [15:0] exp_dst);
    int   k;
    logic pi;
    k = 0;
    pi = (md == MD_INDEX_POSTINC || md == MD_INDEX_SHORT_OFFSET_POSTINC ||
          md == MD_MOVE_POSTINC_TO_DIRECT || md == MD_MOVE_DIRECT_TO_POSTINC);
    while (dec_vld !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("dec_vld", {15'h0, dec_vld}, 16'h0001);
    chk("page2", {15'h0, page2}, {15'h0, p2});
    chk("opcode", {8'h00, opcode}, {8'h00, opc});
    chk("mode", {12'h0, mode}, {12'h0, md});
    chk("illegal", {15'h0, illegal}, {15'h0, md == MD_ILLEGAL});
    // moves through the index pair step it just like the other post-increment forms
    chk("hx_wr", {15'h0, hx_wr}, {15'h0, pi});
    if (pi) chk("hx_next", hx_next, hx + HX_STEP);
    if (md != MD_ILLEGAL) begin
      chk("ea", ea, exp_ea);
      chk("dst_ea", dst_ea, exp_dst);
    end
    @(posedge clk);
    #1;
  endtask

  // long stack offsets, back to back and with a stalled fetch that wraps
  task automatic t_stack_long;
    sp = 16'h1000;
    mem.send('{8'h9e, 8'hd6, 8'h12, 8'h34}, 0);
    get_dec(1'b1, 8'hd6, MD_STACK_REL_LONG_OFFSET, 16'h2234, 16'h0000);
    sp = 16'hff00;
    mem.send('{8'h9e, 8'hdb, 8'h01, 8'h20}, 2);
    get_dec(1'b1, 8'hdb, MD_STACK_REL_LONG_OFFSET, 16'h0020, 16'h0000);
  endtask

  // every 6x and Ex page-two opcode: short stack form or a hole
  task automatic t_stack_short;
    logic [7:0] op;
    logic       ill;
    sp = 16'hfff0;
    for (int n = 0; n < 32; n++) begin
      op = (n < 16) ? {4'h6, 4'(n)} : {4'he, 4'(n)};
      ill = (op == 8'h62 || op == 8'h65 || op == 8'h6e || op == 8'hec || op == 8'hed);
      if (ill) begin
        mem.send('{8'h9e, op}, 0);
        get_dec(1'b1, op, MD_ILLEGAL, 16'h0000, 16'h0000);
      end else begin
        mem.send('{8'h9e, op, 8'hff}, 0);
        get_dec(1'b1, op, MD_STACK_REL_SHORT_OFFSET, 16'h00ef, 16'h0000);
      end
    end
  endtask

  // index pair alone and with short and long offsets, both pages
  task automatic t_index;
    hx = 16'h8000;
    mem.send('{8'hf6}, 0);
    get_dec(1'b0, 8'hf6, MD_INDEX_NO_OFFSET, 16'h8000, 16'h0000);
    mem.send('{8'he6, 8'h10}, 1);
    get_dec(1'b0, 8'he6, MD_INDEX_SHORT_OFFSET, 16'h8010, 16'h0000);
    mem.send('{8'hd6, 8'h01, 8'h02}, 0);
    get_dec(1'b0, 8'hd6, MD_INDEX_LONG_OFFSET, 16'h8102, 16'h0000);
    mem.send('{8'h9e, 8'hbe, 8'h00, 8'h05}, 0);
    get_dec(1'b1, 8'hbe, MD_INDEX_LONG_OFFSET, 16'h8005, 16'h0000);
    mem.send('{8'h9e, 8'hce, 8'h7f}, 0);
    get_dec(1'b1, 8'hce, MD_INDEX_SHORT_OFFSET, 16'h807f, 16'h0000);
  endtask

  // post-increment forms at the top of the address space
  task automatic t_postinc;
    hx = 16'hffff;
    mem.send('{8'h71}, 0);
    get_dec(1'b0, 8'h71, MD_INDEX_POSTINC, 16'hffff, 16'h0000);
    mem.send('{8'h61, 8'h03}, 0);
    get_dec(1'b0, 8'h61, MD_INDEX_SHORT_OFFSET_POSTINC, 16'h0002, 16'h0000);
  endtask

  // the four move pairings
  task automatic t_moves;
    hx = 16'h0040;
    mem.send('{8'h4e, 8'haa, 8'hbb}, 0);
    get_dec(1'b0, 8'h4e, MD_MOVE_DIRECT_TO_DIRECT, 16'h00aa, 16'h00bb);
    mem.send('{8'h5e, 8'haa}, 0);
    get_dec(1'b0, 8'h5e, MD_MOVE_DIRECT_TO_POSTINC, 16'h00aa, 16'h0040);
    mem.send('{8'h6e, 8'h55, 8'hbb}, 1);
    get_dec(1'b0, 8'h6e, MD_MOVE_IMMEDIATE_TO_DIRECT, 16'h0000, 16'h00bb);
    chk("imm", {8'h00, imm}, 16'h0055);
    mem.send('{8'h7e, 8'hbb}, 0);
    get_dec(1'b0, 8'h7e, MD_MOVE_POSTINC_TO_DIRECT, 16'h0040, 16'h00bb);
  endtask

  // an unfinished page-two instruction is dropped by the next first byte
  task automatic t_abort;
    hx = 16'h1234;
    mem.send('{8'h9e, 8'hd6, 8'h12}, 0);
    repeat (2) begin
      chk("no_dec", {15'h0, dec_vld}, 16'h0000);
      @(posedge clk);
      #1;
    end
    mem.send('{8'h71}, 0);
    get_dec(1'b0, 8'h71, MD_INDEX_POSTINC, 16'h1234, 16'h0000);
  endtask

  // verdict and end of run
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_stack_long();
    t_stack_short();
    t_index();
    t_postinc();
    t_moves();
    t_abort();
    end_sim();
  end

  // watchdog: the run needs well under 1000 cycles
  initial begin
    #200000;
    errors++;
    end_sim();
  end
endmodule // p2dec_test
